// File: logic/fcws_pkg.sv
// constants shared by the flash host controller files
// Functional notes
// - command cycles are writes, except reads noted
// - read-mode bank returns array data directly
// - reset command leaves identification or timeout state
// - identification read presents the bank address
// - bypass program needs entry; bypass reset leaves
// - erase suspend only during sector erase; the flash model also takes it during chip erase
// - full byte valid only on a later read
package fcws_pkg;
	localparam int FL_AW = 21;
	localparam int FL_DW = 16;
	localparam int SW_AW = 8;
	localparam int SW_DW = 32;

	// software register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;

	// status field positions
	localparam int ST_BUSY   = 0;
	localparam int ST_DONE   = 1;
	localparam int ST_FAIL   = 2;
	localparam int ST_READY  = 3;
	localparam int ST_ETIMER = 4;
	localparam int ST_TOUT   = 5;

	// status bit positions in the flash data word
	localparam int POLL_BIT   = 7;
	localparam int TOG1_BIT   = 6;
	localparam int TOUT_BIT   = 5;
	localparam int ETIMER_BIT = 3;

	// operation codes written to the control register
	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_PROGRAM    = 4'h1,
		OP_SECT_ERASE = 4'h2,
		OP_CHIP_ERASE = 4'h3,
		OP_SUSPEND    = 4'h4,
		OP_RESUME     = 4'h5,
		OP_RESET      = 4'h6,
		OP_IDENT      = 4'h7,
		OP_BYP_ENTER  = 4'h8,
		OP_BYP_PROG   = 4'h9,
		OP_BYP_RESET  = 4'ha
	} fcws_op_t;

	// command values
	localparam logic [7:0] CMD_UNLOCK1  = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2  = 8'h55;
	localparam logic [7:0] CMD_PROGRAM  = 8'ha0;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_SECTOR   = 8'h30;
	localparam logic [7:0] CMD_CHIP     = 8'h10;
	localparam logic [7:0] CMD_SUSPEND  = 8'hb0;
	localparam logic [7:0] CMD_RESUME   = 8'h30;
	localparam logic [7:0] CMD_RESET    = 8'hf0;
	localparam logic [7:0] CMD_IDENT    = 8'h90;
	localparam logic [7:0] CMD_BYPASS   = 8'h20;
	localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
	localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
	localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;

	// bus cycle timing
	localparam int CLK_MHZ      = 25;
	localparam int T_WE_NS      = 35;
	localparam int T_ACCESS_NS  = 90;
	localparam int SYNC_STAGES  = 2;
	localparam int WE_CYC_RAW   = (T_WE_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC_RAW  = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_CYC       = (WE_CYC_RAW < 1) ? 1 : WE_CYC_RAW;
	localparam int RD_CYC       = ACC_CYC_RAW + SYNC_STAGES + 1;
	localparam logic [3:0] WE_CNT = 4'(WE_CYC - 1);
	localparam logic [3:0] RD_CNT = 4'(RD_CYC - 1);
endpackage

// File: logic/fcws_bus_cycle.sv
// one asynchronous flash read or write cycle from the system clock
`timescale 1ns/10ps
`default_nettype none
module fcws_bus_cycle (
	input  wire logic                      sys_clk_in,
	input  wire logic                      sys_rst_in,
	input  wire logic                      start_in,
	input  wire logic                      is_read_in,
	input  wire logic [fcws_pkg::FL_AW-1:0] addr_in,
	input  wire logic [fcws_pkg::FL_DW-1:0] data_in,
	input  wire logic [fcws_pkg::FL_DW-1:0] fl_dq_in,
	output logic                           done_out,
	output logic [fcws_pkg::FL_DW-1:0]      rdata_out,
	output logic [fcws_pkg::FL_AW-1:0]      fl_addr_out,
	output logic [fcws_pkg::FL_DW-1:0]      fl_dq_out,
	output logic                           fl_dq_oe_out,
	output logic                           fl_we_n_out,
	output logic                           fl_oe_n_out,
	output logic                           fl_ce_n_out
);
	import fcws_pkg::*;

	typedef enum logic [3:0] {
		E_IDLE  = 4'b0001,
		E_SETUP = 4'b0010,
		E_PULSE = 4'b0100,
		E_HOLD  = 4'b1000
	} fcws_eng_t;

	fcws_eng_t          st_q, st_d;
	logic [3:0]         cnt_q, cnt_d;
	logic               rd_q, rd_d;
	logic [FL_AW-1:0]   addr_q, addr_d;
	logic [FL_DW-1:0]   dout_q, dout_d;
	logic               oe_q, oe_d;
	logic               we_n_q, we_n_d;
	logic               oe_n_q, oe_n_d;
	logic               ce_n_q, ce_n_d;
	logic               done_q, done_d;
	logic [FL_DW-1:0]   rdata_q, rdata_d;
	logic [FL_DW-1:0]   dq_s1_q;
	logic [FL_DW-1:0]   dq_s2_q;

	// cycle phases; select drops every cycle so each read ends cleanly
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		addr_d = addr_q;
		dout_d = dout_q;
		oe_d = oe_q;
		we_n_d = we_n_q;
		oe_n_d = oe_n_q;
		ce_n_d = ce_n_q;
		done_d = 1'b0;
		rdata_d = rdata_q;
		case (st_q)
			E_IDLE:
			begin
				if (start_in)
				begin
					rd_d = is_read_in;
					addr_d = addr_in;
					dout_d = data_in;
					ce_n_d = 1'b0;
					oe_d = ~is_read_in;
					st_d = E_SETUP;
				end
			end
			E_SETUP:
			begin
				// address settled before the later falling strobe
				cnt_d = rd_q ? RD_CNT : WE_CNT;
				oe_n_d = ~rd_q;
				we_n_d = rd_q;
				st_d = E_PULSE;
			end
			E_PULSE:
			begin
				if (cnt_q == 4'h0)
				begin
					we_n_d = 1'b1;
					oe_n_d = 1'b1;
					if (rd_q)
						rdata_d = dq_s2_q;
					st_d = E_HOLD;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			E_HOLD:
			begin
				// data still driven past the rising strobe edge
				ce_n_d = 1'b1;
				oe_d = 1'b0;
				done_d = 1'b1;
				st_d = E_IDLE;
			end
			default:
				st_d = E_IDLE;
		endcase
	end

	// registers; the data pins are synchronised before capture
	always_ff @(posedge sys_clk_in)
	begin
		dq_s1_q <= fl_dq_in;
		dq_s2_q <= dq_s1_q;
		if (sys_rst_in)
		begin
			st_q <= E_IDLE;
			cnt_q <= 4'h0;
			rd_q <= 1'b0;
			addr_q <= '0;
			dout_q <= '0;
			oe_q <= 1'b0;
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			ce_n_q <= 1'b1;
			done_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
			we_n_q <= we_n_d;
			oe_n_q <= oe_n_d;
			ce_n_q <= ce_n_d;
			done_q <= done_d;
			rdata_q <= rdata_d;
		end
	end

	assign done_out = done_q;
	assign rdata_out = rdata_q;
	assign fl_addr_out = addr_q;
	assign fl_dq_out = dout_q;
	assign fl_dq_oe_out = oe_q;
	assign fl_we_n_out = we_n_q;
	assign fl_oe_n_out = oe_n_q;
	assign fl_ce_n_out = ce_n_q;
endmodule
`default_nettype wire

// File: logic/fcws_host.sv
// host controller: command sequences and write status polling
`timescale 1ns/10ps
`default_nettype none
module fcws_host (
	input  wire logic                      sys_clk_in,
	input  wire logic                      sys_rst_in,
	input  wire logic [fcws_pkg::SW_AW-1:0] sw_addr_in,
	input  wire logic [fcws_pkg::SW_DW-1:0] sw_wdata_in,
	input  wire logic                      sw_wr_in,
	input  wire logic                      sw_rd_in,
	output logic [fcws_pkg::SW_DW-1:0]      sw_rdata_out,
	output logic [fcws_pkg::FL_AW-1:0]      fl_addr_out,
	input  wire logic [fcws_pkg::FL_DW-1:0] fl_dq_in,
	output logic [fcws_pkg::FL_DW-1:0]      fl_dq_out,
	output logic                           fl_dq_oe_out,
	output logic                           fl_we_n_out,
	output logic                           fl_oe_n_out,
	output logic                           fl_ce_n_out,
	input  wire logic                      ready_busy_open_drain_n_in
);
	import fcws_pkg::*;

	typedef enum logic [4:0] {
		M_IDLE  = 5'b00001,
		M_SEQ   = 5'b00010,
		M_POLL  = 5'b00100,
		M_FINAL = 5'b01000,
		M_ABORT = 5'b10000
	} fcws_main_t;

	fcws_main_t         st_q, st_d;
	fcws_op_t           op_q, op_d;
	logic [FL_AW-1:0]   addr_q, addr_d;
	logic [FL_DW-1:0]   data_q, data_d;
	logic [2:0]         step_q, step_d;
	logic               fly_q, fly_d;
	logic               go_q, go_d;
	logic               pcnt_q, pcnt_d;
	logic               tog_q, tog_d;
	logic               tseen_q, tseen_d;
	logic               done_q, done_d;
	logic               fail_q, fail_d;
	logic               etimer_q, etimer_d;
	logic [FL_DW-1:0]   result_q, result_d;
	logic [SW_DW-1:0]   rdata_q, rdata_d;
	logic               rdy_s1_q;
	logic               rdy_s2_q;

	logic               seq_rd;
	logic               seq_last;
	logic [FL_AW-1:0]   seq_addr;
	logic [7:0]         seq_cmd;
	logic               seq_full;
	logic               cyc_rd;
	logic [FL_AW-1:0]   cyc_addr;
	logic [FL_DW-1:0]   cyc_data;
	logic               cyc_done;
	logic [FL_DW-1:0]   cyc_rdata;
	logic               poll_op;
	logic [FL_AW-1:0]   bank_base;
	logic [FL_AW-1:0]   plain_base;

	// high bits zero on unlock cycles, bank bits where the bank matters
	assign plain_base = '0;
	assign bank_base = {addr_q[FL_AW-1:11], 11'h000};
	assign poll_op = (op_q == OP_PROGRAM) || (op_q == OP_BYP_PROG) ||
		(op_q == OP_SECT_ERASE) || (op_q == OP_CHIP_ERASE);

	// command sequence table indexed by operation and step
	always_comb
	begin
		seq_rd = 1'b0;
		seq_last = 1'b0;
		seq_full = 1'b0;
		seq_addr = plain_base;
		seq_cmd = CMD_RESET;
		if (step_q == 3'h0 && op_q != OP_READ && op_q != OP_SUSPEND &&
			op_q != OP_RESUME && op_q != OP_RESET && op_q != OP_BYP_PROG &&
			op_q != OP_BYP_RESET)
		begin
			seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR1};
			seq_cmd = CMD_UNLOCK1;
		end
		else if (step_q == 3'h1 && (op_q == OP_PROGRAM ||
			op_q == OP_SECT_ERASE || op_q == OP_CHIP_ERASE ||
			op_q == OP_IDENT || op_q == OP_BYP_ENTER))
		begin
			seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR2};
			seq_cmd = CMD_UNLOCK2;
		end
		else
		begin
			case (op_q)
				OP_READ:
				begin
					seq_rd = 1'b1;
					seq_last = 1'b1;
					seq_addr = addr_q;
				end
				OP_PROGRAM, OP_BYP_PROG:
				begin
					// bypass form is only legal after bypass entry
					if ((op_q == OP_PROGRAM) ? (step_q == 3'h2)
						: (step_q == 3'h0))
					begin
						// full form must hit the unlock address; bypass form
						// takes any address
						seq_cmd = CMD_PROGRAM;
						if (op_q == OP_PROGRAM)
							seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR1};
					end
					else
					begin
						seq_addr = addr_q;
						seq_full = 1'b1;
						seq_last = 1'b1;
					end
				end
				OP_SECT_ERASE, OP_CHIP_ERASE:
				begin
					case (step_q)
						3'h2: seq_cmd = CMD_ERASE;
						3'h3: seq_cmd = CMD_UNLOCK1;
						3'h4: seq_cmd = CMD_UNLOCK2;
						default:
						begin
							seq_last = 1'b1;
							seq_cmd = (op_q == OP_SECT_ERASE) ? CMD_SECTOR
								: CMD_CHIP;
							// sector chosen by bits 20..12 of addr_q
							if (op_q == OP_SECT_ERASE)
								seq_addr = {addr_q[20:12], 12'h000};
						end
					endcase
					if (step_q == 3'h2)
						seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR1};
					else if (step_q == 3'h3)
						seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR1};
					else if (step_q == 3'h4)
						seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR2};
					else if (op_q == OP_CHIP_ERASE)
						seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR1};
				end
				OP_IDENT:
				begin
					if (step_q == 3'h2)
					begin
						seq_addr = {bank_base[FL_AW-1:11], UNLOCK_ADDR1};
						seq_cmd = CMD_IDENT;
					end
					else
					begin
						seq_rd = 1'b1;
						seq_addr = addr_q;
						seq_last = 1'b1;
					end
				end
				OP_BYP_ENTER:
				begin
					seq_addr = {plain_base[FL_AW-1:11], UNLOCK_ADDR1};
					seq_cmd = CMD_BYPASS;
					seq_last = 1'b1;
				end
				OP_BYP_RESET:
				begin
					seq_addr = (step_q == 3'h0) ? bank_base : plain_base;
					seq_cmd = (step_q == 3'h0) ? CMD_IDENT : CMD_BYP_EXIT;
					seq_last = (step_q != 3'h0);
				end
				OP_SUSPEND, OP_RESUME:
				begin
					seq_addr = bank_base;
					seq_cmd = (op_q == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
					seq_last = 1'b1;
				end
				default:
				begin
					seq_cmd = CMD_RESET;
					seq_last = 1'b1;
				end
			endcase
		end
	end

	// cycle handed to the engine; command bytes carry a zero upper byte
	always_comb
	begin
		cyc_rd = 1'b1;
		cyc_addr = addr_q;
		cyc_data = '0;
		case (st_q)
			M_SEQ:
			begin
				cyc_rd = seq_rd;
				cyc_addr = seq_addr;
				cyc_data = seq_full ? data_q : {8'h00, seq_cmd};
			end
			M_ABORT:
			begin
				cyc_rd = 1'b0;
				cyc_addr = plain_base;
				cyc_data = {8'h00, CMD_RESET};
			end
			default:
			begin
				cyc_rd = 1'b1;
				cyc_addr = addr_q;
			end
		endcase
	end

	// sequencer and toggle polling
	always_comb
	begin
		st_d = st_q;
		op_d = op_q;
		addr_d = addr_q;
		data_d = data_q;
		step_d = step_q;
		fly_d = fly_q;
		go_d = 1'b0;
		pcnt_d = pcnt_q;
		tog_d = tog_q;
		tseen_d = tseen_q;
		done_d = done_q;
		fail_d = fail_q;
		etimer_d = etimer_q;
		result_d = result_q;
		rdata_d = '0;
		if (st_q != M_IDLE && !fly_q && !go_q)
		begin
			go_d = 1'b1;
			fly_d = 1'b1;
		end
		if (cyc_done)
			fly_d = 1'b0;
		case (st_q)
			M_IDLE:
			begin
				if (sw_wr_in && sw_addr_in == REG_CTRL)
				begin
					op_d = fcws_op_t'(sw_wdata_in[3:0]);
					step_d = 3'h0;
					done_d = 1'b0;
					fail_d = 1'b0;
					etimer_d = 1'b0;
					st_d = M_SEQ;
				end
				if (sw_wr_in && sw_addr_in == REG_ADDR)
					addr_d = sw_wdata_in[FL_AW-1:0];
				if (sw_wr_in && sw_addr_in == REG_DATA)
					data_d = sw_wdata_in[FL_DW-1:0];
			end
			M_SEQ:
			begin
				if (cyc_done)
				begin
					if (!seq_last)
						step_d = step_q + 3'h1;
					else if (poll_op)
					begin
						pcnt_d = 1'b0;
						tseen_d = 1'b0;
						st_d = M_POLL;
					end
					else
					begin
						if (seq_rd)
							result_d = cyc_rdata;
						done_d = 1'b1;
						st_d = M_IDLE;
					end
				end
			end
			M_POLL:
			begin
				// two reads in a row decide whether the bit still toggles
				if (cyc_done)
				begin
					tog_d = cyc_rdata[TOG1_BIT];
					pcnt_d = 1'b1;
					if (cyc_rdata[ETIMER_BIT])
						etimer_d = 1'b1;
					if (pcnt_q && cyc_rdata[TOG1_BIT] == tog_q)
						st_d = M_FINAL;
					else if (pcnt_q && tseen_q)
						st_d = M_ABORT;
					else if (pcnt_q && cyc_rdata[TOUT_BIT])
					begin
						// toggle may stop just as the flag rises: recheck
						tseen_d = 1'b1;
						pcnt_d = 1'b0;
					end
				end
			end
			M_FINAL:
			begin
				// polling bit can settle early; take the byte a read later
				if (cyc_done)
				begin
					result_d = cyc_rdata;
					done_d = 1'b1;
					st_d = M_IDLE;
				end
			end
			M_ABORT:
			begin
				if (cyc_done)
				begin
					fail_d = 1'b1;
					done_d = 1'b1;
					st_d = M_IDLE;
				end
			end
			default:
				st_d = M_IDLE;
		endcase
		// register read port
		if (sw_rd_in)
		begin
			case (sw_addr_in)
				REG_CTRL:
					rdata_d = {28'h0000000, op_q};
				REG_ADDR:
					rdata_d = {11'h000, addr_q};
				REG_DATA:
					rdata_d = {16'h0000, data_q};
				REG_STATUS:
				begin
					rdata_d[ST_BUSY] = (st_q != M_IDLE);
					rdata_d[ST_DONE] = done_q;
					rdata_d[ST_FAIL] = fail_q;
					rdata_d[ST_READY] = rdy_s2_q;
					rdata_d[ST_ETIMER] = etimer_q;
					rdata_d[ST_TOUT] = tseen_q;
				end
				REG_RESULT:
					rdata_d = {16'h0000, result_q};
				default:
					rdata_d = '0;
			endcase
		end
	end

	// state registers; ready pin passes two flip-flops first
	always_ff @(posedge sys_clk_in)
	begin
		rdy_s1_q <= ready_busy_open_drain_n_in;
		rdy_s2_q <= rdy_s1_q;
		if (sys_rst_in)
		begin
			st_q <= M_IDLE;
			op_q <= OP_READ;
			addr_q <= '0;
			data_q <= '0;
			step_q <= 3'h0;
			fly_q <= 1'b0;
			go_q <= 1'b0;
			pcnt_q <= 1'b0;
			tog_q <= 1'b0;
			tseen_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			etimer_q <= 1'b0;
			result_q <= '0;
			rdata_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			op_q <= op_d;
			addr_q <= addr_d;
			data_q <= data_d;
			step_q <= step_d;
			fly_q <= fly_d;
			go_q <= go_d;
			pcnt_q <= pcnt_d;
			tog_q <= tog_d;
			tseen_q <= tseen_d;
			done_q <= done_d;
			fail_q <= fail_d;
			etimer_q <= etimer_d;
			result_q <= result_d;
			rdata_q <= rdata_d;
		end
	end

	assign sw_rdata_out = rdata_q;

	fcws_bus_cycle u_cycle (
		.sys_clk_in   (sys_clk_in),
		.sys_rst_in   (sys_rst_in),
		.start_in     (go_q),
		.is_read_in   (cyc_rd),
		.addr_in      (cyc_addr),
		.data_in      (cyc_data),
		.fl_dq_in     (fl_dq_in),
		.done_out     (cyc_done),
		.rdata_out    (cyc_rdata),
		.fl_addr_out  (fl_addr_out),
		.fl_dq_out    (fl_dq_out),
		.fl_dq_oe_out (fl_dq_oe_out),
		.fl_we_n_out  (fl_we_n_out),
		.fl_oe_n_out  (fl_oe_n_out),
		.fl_ce_n_out  (fl_ce_n_out)
	);
endmodule
`default_nettype wire

// File: verification/fcws_host_assertions.sv
// concurrent checks on the flash host controller ports
`timescale 1ns/10ps
`default_nettype none
module fcws_host_assertions (
	input wire logic                        sys_clk_in,
	input wire logic                        sys_rst_in,
	input wire logic [fcws_pkg::FL_AW-1:0]  fl_addr_out,
	input wire logic [fcws_pkg::FL_DW-1:0]  fl_dq_out,
	input wire logic                        fl_dq_oe_out,
	input wire logic                        fl_we_n_out,
	input wire logic                        fl_oe_n_out,
	input wire logic                        fl_ce_n_out
);
	import fcws_pkg::*;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	// output enable stays low for the whole access, then ends the read
	sequence s_read_pulse;
		!fl_oe_n_out [*6] ##1 fl_oe_n_out;
	endsequence
	// two idle clocks so the device sees separate cycles
	sequence s_idle_gap;
		fl_ce_n_out [*2];
	endsequence

	property p_we_in_select;
		!fl_we_n_out |-> !fl_ce_n_out && fl_dq_oe_out;
	endproperty
	a_we_in_select: assert property (p_we_in_select)
		else $error("write strobe outside select or undriven bus");
	property p_we_one_cycle;
		$fell(fl_we_n_out) |=> fl_we_n_out;
	endproperty
	a_we_one_cycle: assert property (p_we_one_cycle)
		else $error("write strobe width wrong");
	property p_read_no_drive;
		!fl_oe_n_out |-> !fl_dq_oe_out && fl_we_n_out;
	endproperty
	a_read_no_drive: assert property (p_read_no_drive)
		else $error("bus driven during a read");
	property p_read_pulse;
		$fell(fl_oe_n_out) |-> s_read_pulse;
	endproperty
	a_read_pulse: assert property (p_read_pulse)
		else $error("read strobe length wrong");
	property p_oe_in_select;
		!fl_oe_n_out |-> !fl_ce_n_out;
	endproperty
	a_oe_in_select: assert property (p_oe_in_select)
		else $error("read strobe outside select");
	property p_addr_stable;
		!fl_ce_n_out && $past(!fl_ce_n_out) |->
			$stable(fl_addr_out) && $stable(fl_dq_out);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("address or data moved inside a cycle");
	property p_gap;
		$rose(fl_ce_n_out) |-> s_idle_gap;
	endproperty
	a_gap: assert property (p_gap)
		else $error("cycles too close together");
	property p_data_hold;
		$rose(fl_we_n_out) |-> fl_dq_oe_out ##[1:2] !fl_dq_oe_out;
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("data not held past write strobe rise");
endmodule
bind fcws_host fcws_host_assertions u_chk (.sys_clk_in, .sys_rst_in,
	.fl_addr_out, .fl_dq_out, .fl_dq_oe_out, .fl_we_n_out, .fl_oe_n_out,
	.fl_ce_n_out);
`default_nettype wire

// File: verification/fcws_flash_model.sv
// behavioural flash device facing the host controller
`timescale 1ns/10ps
`default_nettype none
module fcws_flash_model #(
	parameter int          BUSY_READS = 4,
	parameter logic [15:0] MAKER_ID   = 16'h005a, // arbitrary value
	parameter logic [8:0]  PROT_SECT  = 9'h1f0,
	parameter bit          LOCKED     = 1'b1
) (
	input  wire logic [20:0] fl_addr_in,
	input  wire logic [15:0] fl_dq_in,
	input  wire logic        fl_we_n_in,
	input  wire logic        fl_oe_n_in,
	input  wire logic        fl_ce_n_in,
	input  wire logic        fail_mode_in,
	output logic [15:0]      fl_dq_out,
	output logic             ready_busy_open_drain_n_out
);
	logic [15:0] mem [16];
	logic [15:0] pv, drv;
	logic [20:0] a_lat, pa;
	logic [2:0]  step;
	logic        busy, erasing, ident, byp, tog, tout, reading, susp, ok;
	int          cnt;
	wire  [7:0]  d = fl_dq_in[7:0];
	// one protected sector, picked by the sector address bits
	wire         prot = (pa[20:12] == PROT_SECT);
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hffff;
		{busy, erasing, ident, byp, tog, tout, reading, susp, step} = '0;
		drv = '0;
	end
	// address taken at the later falling strobe, select already low
	always @(negedge fl_we_n_in) if (!fl_ce_n_in) a_lat = fl_addr_in;
	// command decode on write strobe rise; only low address bits matter
	always @(posedge fl_we_n_in)
	begin
		if (!fl_ce_n_in && d == 8'hf0)
			{busy, tout, ident, erasing, susp, step} = '0;
		else if (!fl_ce_n_in && busy && erasing)
			// only reset, suspend and resume are taken while an erase runs
			susp = (d == 8'hb0) ? 1'b1 : (d == 8'h30) ? 1'b0 : susp;
		else if (!fl_ce_n_in && !busy)
			case (step)
				3'd0: step = (byp && d == 8'ha0) ? 3'd3 :
					(byp && d == 8'h90) ? 3'd7 :
					(a_lat[10:0] == 11'h555 && d == 8'haa) ? 3'd1 : 3'd0;
				3'd1: step = (a_lat[10:0] == 11'h2aa && d == 8'h55) ? 3'd2 : 3'd0;
				3'd2:
				begin
					// third command cycle must hit the first unlock address
					ok    = (a_lat[10:0] == 11'h555);
					ident = ok && (d == 8'h90);
					byp   = byp | (ok && d == 8'h20);
					step  = !ok ? 3'd0 : (d == 8'ha0) ? 3'd3 :
						(d == 8'h80) ? 3'd4 : 3'd0;
				end
				3'd4: step = (d == 8'haa) ? 3'd5 : 3'd0;
				3'd5: step = (d == 8'h55) ? 3'd6 : 3'd0;
				3'd7: {byp, step} = {d != 8'h00, 3'd0};
				default:
				begin
					// program value only clears bits; erase sets them
					erasing = (step == 3'd6);
					pa      = a_lat;
					pv      = fl_dq_in & mem[a_lat[3:0]];
					busy    = (step == 3'd3) || d == 8'h30 || d == 8'h10;
					cnt     = BUSY_READS;
					tout    = fail_mode_in;
					step    = 3'd0;
				end
			endcase
	end
	// status while busy in the target bank, identification or array data otherwise
	always @(negedge fl_oe_n_in)
	begin
		reading = !fl_ce_n_in;
		if (busy && fl_addr_in[20] == pa[20])
			drv = {8'h00, erasing ? susp : ~pv[7], tog, tout, 1'b0, erasing,
				tog & erasing, 2'b00};
		else if (ident)
			case (fl_addr_in[1:0])
				2'h2: drv = {15'h0000, fl_addr_in[20:12] == PROT_SECT};
				2'h3: drv = LOCKED ? 16'h0080 : 16'h0000;
				default: drv = MAKER_ID;
			endcase
		else
			drv = mem[fl_addr_in[3:0]];
	end
	// a read ends at the strobe rise; a failed run never finishes
	always @(posedge fl_oe_n_in)
	begin
		reading = 1'b0;
		if (busy && !susp)
		begin
			tog = ~tog;
			cnt = cnt - 1;
			if (cnt <= 0 && !tout)
			begin
				busy = 1'b0;
				// protected target: busy is shown, data stays untouched
				if (erasing && !prot) foreach (mem[i]) mem[i] = 16'hffff;
				else if (!prot) mem[pa[3:0]] = pv;
				erasing = 1'b0;
			end
		end
	end
	// released bus shows the inverse of the last value, not a held copy
	assign fl_dq_out = reading ? drv : ~drv;
	assign ready_busy_open_drain_n_out = !busy || susp;
endmodule
`default_nettype wire

// File: verification/fcws_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
	error_cnt++; $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module fcws_host_tb;
	import fcws_pkg::*;
	localparam logic [15:0] MAKER = 16'h005a; // arbitrary value
	logic        sys_clk_in = 0, sys_rst_in = 1, sw_wr_in = 0, sw_rd_in = 0;
	logic        fail_mode = 0, fl_dq_oe_out, fl_we_n_out, fl_oe_n_out;
	logic        fl_ce_n_out, rb_n;
	logic [7:0]  sw_addr_in = '0;
	logic [31:0] sw_wdata_in = '0, sw_rdata_out, rd;
	logic [20:0] fl_addr_out;
	logic [15:0] fl_dq_out, dev_dq, fl_dq_in;
	int          error_cnt = 0, compares = 0;
	always #20 sys_clk_in = ~sys_clk_in;
	// the wire carries whoever drives it
	assign fl_dq_in = fl_dq_oe_out ? fl_dq_out : dev_dq;
	fcws_host dut (.sys_clk_in, .sys_rst_in, .sw_addr_in, .sw_wdata_in,
		.sw_wr_in, .sw_rd_in, .sw_rdata_out, .fl_addr_out, .fl_dq_in,
		.fl_dq_out, .fl_dq_oe_out, .fl_we_n_out, .fl_oe_n_out, .fl_ce_n_out,
		.ready_busy_open_drain_n_in(rb_n));
	fcws_flash_model #(.BUSY_READS(4), .MAKER_ID(MAKER),
		.PROT_SECT(9'h1f0), .LOCKED(1'b1)) dev (
		.fl_addr_in(fl_addr_out), .fl_dq_in(fl_dq_out),
		.fl_we_n_in(fl_we_n_out), .fl_oe_n_in(fl_oe_n_out),
		.fl_ce_n_in(fl_ce_n_out), .fail_mode_in(fail_mode),
		.fl_dq_out(dev_dq), .ready_busy_open_drain_n_out(rb_n));
	task automatic final_report();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic sw_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		sw_addr_in  <= a;
		sw_wdata_in <= v;
		sw_wr_in    <= 1'b1;
		@(posedge sys_clk_in);
		sw_wr_in    <= 1'b0;
	endtask
	task automatic sw_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk_in);
		sw_addr_in <= a;
		sw_rd_in   <= 1'b1;
		@(posedge sys_clk_in);
		sw_rd_in   <= 1'b0;
		#1 v = sw_rdata_out;
	endtask
	// start an operation and poll until it is no longer busy
	task automatic run_op(input fcws_op_t op, input logic [20:0] a,
		input logic [15:0] v);
		int n;
		sw_write(REG_ADDR, 32'(a));
		sw_write(REG_DATA, 32'(v));
		sw_write(REG_CTRL, 32'(op));
		n = 0;
		do
		begin
			sw_read(REG_STATUS, rd);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 4000);
		if (n >= 4000)
		begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, rd, 32'h0);
			final_report();
		end
	endtask
	task automatic read_at(input logic [20:0] a, input logic [15:0] e);
		run_op(OP_READ, a, 16'h0);
		sw_read(REG_RESULT, rd);
		`CHK(rd, {16'h0, e})
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		sw_read(REG_STATUS, rd);
		`CHK(rd, 32'h8)
		sw_read(8'h20, rd);
		`CHK(rd, 32'h0)
		$display("test reset done");
		// upper address bits set to show they do not matter
		run_op(OP_PROGRAM, 21'h1ff003, 16'h1234);
		sw_read(REG_STATUS, rd);
		`CHK(rd[ST_FAIL:ST_BUSY], 3'b010)
		sw_read(REG_RESULT, rd);
		`CHK(rd, 32'h1234)
		read_at(21'h000003, 16'h1234);
		$display("test program done");
		for (int i = 0; i < 2; i++)
		begin
			run_op(i ? OP_CHIP_ERASE : OP_SECT_ERASE, 21'h003000, 16'h0);
			sw_read(REG_STATUS, rd);
			`CHK(rd[ST_ETIMER], 1'b1)
			read_at(21'h000003, 16'hffff);
		end
		$display("test erase done");
		run_op(OP_IDENT, 21'h100000, 16'h0);
		sw_read(REG_RESULT, rd);
		`CHK(rd, {16'h0, MAKER})
		read_at(21'h1f0002, 16'h0001);
		read_at(21'h000003, 16'h0080);
		run_op(OP_RESET, 21'h0, 16'h0);
		read_at(21'h000003, 16'hffff);
		$display("test ident done");
		run_op(OP_BYP_ENTER, 21'h0, 16'h0);
		run_op(OP_BYP_PROG, 21'h000005, 16'h00a5);
		run_op(OP_BYP_RESET, 21'h0, 16'h0);
		read_at(21'h000005, 16'h00a5);
		run_op(OP_SUSPEND, 21'h0, 16'h0);
		run_op(OP_RESUME, 21'h0, 16'h0);
		read_at(21'h000005, 16'h00a5);
		$display("test bypass done");
		// protected target: brief busy, no change, no failure
		run_op(OP_PROGRAM, 21'h1f0007, 16'h0000);
		sw_read(REG_STATUS, rd);
		`CHK(rd[ST_FAIL:ST_BUSY], 3'b010)
		read_at(21'h1f0007, 16'hffff);
		$display("test protect done");
		fail_mode <= 1'b1;
		run_op(OP_PROGRAM, 21'h000006, 16'h0f0f);
		fail_mode <= 1'b0;
		sw_read(REG_STATUS, rd);
		`CHK({rd[ST_TOUT], rd[ST_FAIL], rd[ST_DONE]}, 3'b111)
		read_at(21'h000006, 16'hffff);
		$display("test timeout done");
		final_report();
	end
endmodule
`default_nettype wire
